// ==== pieb_map.vh ====
// Register offsets, field positions and reset values for the peripheral enable bank
`ifndef PIEB_MAP_VH
`define PIEB_MAP_VH
`define PIEB_ADDR_W 12
`define PIEB_OFF_EN_FIVE 12'h4ad
`define PIEB_OFF_EN_SIX 12'h4ae
`define PIEB_OFF_EN_SEVEN 12'h4af
`define PIEB_OFF_EN_EIGHT 12'h4b0
`define PIEB_OFF_EN_NINE 12'h4b1
`define PIEB_OFF_EN_TEN 12'h4b2
`define PIEB_OFF_REQ_ZERO 12'h4b3
`define PIEB_OFF_EVT_STAT 12'h4c0
`define PIEB_OFF_EVT_MASK 12'h4c1
`define PIEB_MASK_EN_FIVE 8'h03
`define PIEB_MASK_EN_SIX 8'hfd
`define PIEB_MASK_EN_SEVEN 8'hef
`define PIEB_MASK_EN_EIGHT 8'haf
`define PIEB_MASK_EN_NINE 8'hff
`define PIEB_MASK_EN_TEN 8'hf9
`define PIEB_MASK_REQ_HS 8'h7e
`define PIEB_BIT_PIN_CHANGE 7
`define PIEB_BIT_SOFT_IRQ 0
`define PIEB_RST_BYTE 8'h00
`define PIEB_EVT_W 2
`define PIEB_EVT_FLAG_SET 0
`define PIEB_EVT_SOFT_SET 1
`endif

// ==== pieb_flag_bit.v ====
// One hardware-set, software-cleared sticky flag bit
`timescale 1ns/100ps
module pieb_flag_bit (
  input wire i_ref_clk,
  input wire i_rst,
  input wire i_set,
  input wire i_wr,
  input wire i_wr_val,
  output reg o_flag_q
);
  always @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_flag_q <= 1'b0;
    end else if (i_set) begin
      // Set beats a same-cycle software clear so no event is lost
      o_flag_q <= 1'b1;
    end else if (i_wr) begin
      o_flag_q <= i_wr_val;
    end
  end
endmodule // pieb_flag_bit

// ==== pieb_enable_bank.v ====
// Peripheral interrupt enable bank with request register zero
// How it works
// - Enable one passes source, zero blocks it
// - Earlier register holds SPI-b tx/rx enables
// - Sixth enable register, DMA-b and misc sources
// - Seventh enable register, PWM-c, logic, I2C
// - Eighth enable register, scanner, logic, UART-b
// - Ninth enable register, DMA-c and UART-c
// - Tenth enable register, DMA-d, timer, external
// - Request zero: mixed access flags, reset zero
// - Flags set regardless of enable bits
// - Pin-change flag follows per-pin change flags
// - Software flag written only by software
//
// Added by the designer: the strobed register port.
`timescale 1ns/100ps
`include "pieb_map.vh"
module pieb_enable_bank #(
  parameter ADDR_W = `PIEB_ADDR_W
) (
  input wire i_ref_clk,
  input wire i_rst,
  input wire [ADDR_W-1:0] i_addr,
  input wire [7:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output reg [7:0] o_rdata,
  input wire [7:0] i_src_five,
  input wire [7:0] i_src_six,
  input wire [7:0] i_src_seven,
  input wire [7:0] i_src_eight,
  input wire [7:0] i_src_nine,
  input wire [7:0] i_src_ten,
  input wire [7:0] i_req_zero_set,
  input wire i_pin_change_any,
  output wire [7:0] o_req_five,
  output wire [7:0] o_req_six,
  output wire [7:0] o_req_seven,
  output wire [7:0] o_req_eight,
  output wire [7:0] o_req_nine,
  output wire [7:0] o_req_ten,
  output wire [7:0] o_req_zero,
  output wire [7:0] o_req_zero_flags,
  output wire o_irq
);
  reg [7:0] en_five_q;
  reg [7:0] en_six_q;
  reg [7:0] en_seven_q;
  reg [7:0] en_eight_q;
  reg [7:0] en_nine_q;
  reg [7:0] en_ten_q;
  reg [7:0] en_zero_q;
  reg soft_flag_q;
  reg pin_change_q;
  reg [`PIEB_EVT_W-1:0] evt_stat_q;
  reg [`PIEB_EVT_W-1:0] evt_mask_q;
  reg [`PIEB_EVT_W-1:0] evt_stat_d;
  reg [7:0] rdata_d;
  wire [7:0] flags_zero;
  wire [7:0] hs_set;
  wire [7:0] req_flag_q;
  wire wr_req;
  wire rd_stat;
  wire [`PIEB_EVT_W-1:0] evt_now;

  assign wr_req = i_wr && (i_addr == `PIEB_OFF_REQ_ZERO);
  assign hs_set = i_req_zero_set & `PIEB_MASK_REQ_HS;

  genvar g;
  generate
    for (g = 1; g < 7; g = g + 1) begin : g_flag
      pieb_flag_bit u_flag (
        .i_ref_clk(i_ref_clk),
        .i_rst(i_rst),
        .i_set(hs_set[g]),
        .i_wr(wr_req),
        .i_wr_val(i_wdata[g]),
        .o_flag_q(req_flag_q[g])
      );
    end
  endgenerate
  assign req_flag_q[0] = 1'b0;
  assign req_flag_q[7] = 1'b0;

  // Pin-change flag mirrors the per-pin flags; software cannot write it
  always @(posedge i_ref_clk) begin
    if (i_rst) begin
      pin_change_q <= 1'b0;
    end else begin
      pin_change_q <= i_pin_change_any;
    end
  end

  always @(posedge i_ref_clk) begin
    if (i_rst) begin
      soft_flag_q <= 1'b0;
    end else if (wr_req) begin
      soft_flag_q <= i_wdata[`PIEB_BIT_SOFT_IRQ];
    end
  end

  // Request-zero flag fields, in bit order from seven down to zero
  wire pin_change_flag;
  wire checksum_flag;
  wire logic_cell_a_flag;
  wire nonvolatile_flag;
  wire clock_switch_flag;
  wire osc_fail_flag;
  wire voltage_detect_flag;
  wire soft_irq_flag;
  assign pin_change_flag = pin_change_q;
  assign checksum_flag = req_flag_q[6];
  assign logic_cell_a_flag = req_flag_q[5];
  assign nonvolatile_flag = req_flag_q[4];
  assign clock_switch_flag = req_flag_q[3];
  assign osc_fail_flag = req_flag_q[2];
  assign voltage_detect_flag = req_flag_q[1];
  assign soft_irq_flag = soft_flag_q;
  assign flags_zero = {pin_change_flag, checksum_flag, logic_cell_a_flag, nonvolatile_flag,
    clock_switch_flag, osc_fail_flag, voltage_detect_flag,
    soft_irq_flag};
  assign o_req_zero_flags = flags_zero;

  // Enable registers; unimplemented bits are held at zero
  always @(posedge i_ref_clk) begin
    if (i_rst) begin
      en_five_q <= `PIEB_RST_BYTE;
      en_six_q <= `PIEB_RST_BYTE;
      en_seven_q <= `PIEB_RST_BYTE;
      en_eight_q <= `PIEB_RST_BYTE;
      en_nine_q <= `PIEB_RST_BYTE;
      en_ten_q <= `PIEB_RST_BYTE;
      en_zero_q <= `PIEB_RST_BYTE;
    end else if (i_wr) begin
      if (i_addr == `PIEB_OFF_EN_FIVE) begin
        en_five_q <= i_wdata & `PIEB_MASK_EN_FIVE;
      end else if (i_addr == `PIEB_OFF_EN_SIX) begin
        en_six_q <= i_wdata & `PIEB_MASK_EN_SIX;
      end else if (i_addr == `PIEB_OFF_EN_SEVEN) begin
        en_seven_q <= i_wdata & `PIEB_MASK_EN_SEVEN;
      end else if (i_addr == `PIEB_OFF_EN_EIGHT) begin
        en_eight_q <= i_wdata & `PIEB_MASK_EN_EIGHT;
      end else if (i_addr == `PIEB_OFF_EN_NINE) begin
        en_nine_q <= i_wdata & `PIEB_MASK_EN_NINE;
      end else if (i_addr == `PIEB_OFF_EN_TEN) begin
        en_ten_q <= i_wdata & `PIEB_MASK_EN_TEN;
      end else if (i_addr == `PIEB_OFF_EVT_MASK + 12'h001) begin
        en_zero_q <= i_wdata;
      end
    end
  end

  // Peripheral sources hold their own flags; enable gates forwarding
  // Named enable fields; gaps are tied low so a missing bit never forwards
  wire spi_b_tx_irq_en;
  wire spi_b_rx_irq_en;
  wire dma_b_abort_irq_en;
  wire dma_b_overrun_irq_en;
  wire dma_b_dest_count_irq_en;
  wire dma_b_src_count_irq_en;
  wire num_osc_irq_en;
  wire waveform_gen_irq_en;
  wire ext_irq_b_en;
  wire pwm_c_param_irq_en;
  wire pwm_c_period_irq_en;
  wire logic_cell_c_irq_en;
  wire i2c_error_irq_en;
  wire i2c_general_irq_en;
  wire i2c_tx_irq_en;
  wire i2c_rx_irq_en;
  wire mem_scanner_irq_en;
  wire logic_cell_d_irq_en;
  wire uart_b_irq_en;
  wire uart_b_frame_err_irq_en;
  wire uart_b_tx_irq_en;
  wire uart_b_rx_irq_en;
  wire dma_c_abort_irq_en;
  wire dma_c_overrun_irq_en;
  wire dma_c_dest_count_irq_en;
  wire dma_c_src_count_irq_en;
  wire uart_c_irq_en;
  wire uart_c_frame_err_irq_en;
  wire uart_c_tx_irq_en;
  wire uart_c_rx_irq_en;
  wire dma_d_abort_irq_en;
  wire dma_d_overrun_irq_en;
  wire dma_d_dest_count_irq_en;
  wire dma_d_src_count_irq_en;
  wire timer_d_irq_en;
  wire ext_irq_c_en;
  assign spi_b_tx_irq_en = en_five_q[1];
  assign spi_b_rx_irq_en = en_five_q[0];
  assign dma_b_abort_irq_en = en_six_q[7];
  assign dma_b_overrun_irq_en = en_six_q[6];
  assign dma_b_dest_count_irq_en = en_six_q[5];
  assign dma_b_src_count_irq_en = en_six_q[4];
  assign num_osc_irq_en = en_six_q[3];
  assign waveform_gen_irq_en = en_six_q[2];
  assign ext_irq_b_en = en_six_q[0];
  assign pwm_c_param_irq_en = en_seven_q[7];
  assign pwm_c_period_irq_en = en_seven_q[6];
  assign logic_cell_c_irq_en = en_seven_q[5];
  assign i2c_error_irq_en = en_seven_q[3];
  assign i2c_general_irq_en = en_seven_q[2];
  assign i2c_tx_irq_en = en_seven_q[1];
  assign i2c_rx_irq_en = en_seven_q[0];
  assign mem_scanner_irq_en = en_eight_q[7];
  assign logic_cell_d_irq_en = en_eight_q[5];
  assign uart_b_irq_en = en_eight_q[3];
  assign uart_b_frame_err_irq_en = en_eight_q[2];
  assign uart_b_tx_irq_en = en_eight_q[1];
  assign uart_b_rx_irq_en = en_eight_q[0];
  assign dma_c_abort_irq_en = en_nine_q[7];
  assign dma_c_overrun_irq_en = en_nine_q[6];
  assign dma_c_dest_count_irq_en = en_nine_q[5];
  assign dma_c_src_count_irq_en = en_nine_q[4];
  assign uart_c_irq_en = en_nine_q[3];
  assign uart_c_frame_err_irq_en = en_nine_q[2];
  assign uart_c_tx_irq_en = en_nine_q[1];
  assign uart_c_rx_irq_en = en_nine_q[0];
  assign dma_d_abort_irq_en = en_ten_q[7];
  assign dma_d_overrun_irq_en = en_ten_q[6];
  assign dma_d_dest_count_irq_en = en_ten_q[5];
  assign dma_d_src_count_irq_en = en_ten_q[4];
  assign timer_d_irq_en = en_ten_q[3];
  assign ext_irq_c_en = en_ten_q[0];
  assign o_req_five = i_src_five & {6'h00, spi_b_tx_irq_en, spi_b_rx_irq_en};
  assign o_req_six = i_src_six & {dma_b_abort_irq_en, dma_b_overrun_irq_en,
    dma_b_dest_count_irq_en, dma_b_src_count_irq_en, num_osc_irq_en,
    waveform_gen_irq_en, 1'b0, ext_irq_b_en};
  assign o_req_seven = i_src_seven & {pwm_c_param_irq_en, pwm_c_period_irq_en,
    logic_cell_c_irq_en, 1'b0, i2c_error_irq_en, i2c_general_irq_en, i2c_tx_irq_en,
    i2c_rx_irq_en};
  assign o_req_eight = i_src_eight & {mem_scanner_irq_en, 1'b0, logic_cell_d_irq_en, 1'b0,
    uart_b_irq_en, uart_b_frame_err_irq_en, uart_b_tx_irq_en,
    uart_b_rx_irq_en};
  assign o_req_nine = i_src_nine & {dma_c_abort_irq_en, dma_c_overrun_irq_en,
    dma_c_dest_count_irq_en, dma_c_src_count_irq_en, uart_c_irq_en,
    uart_c_frame_err_irq_en, uart_c_tx_irq_en, uart_c_rx_irq_en};
  assign o_req_ten = i_src_ten & {dma_d_abort_irq_en, dma_d_overrun_irq_en,
    dma_d_dest_count_irq_en, dma_d_src_count_irq_en, timer_d_irq_en, 2'b00,
    ext_irq_c_en};
  assign o_req_zero = flags_zero & en_zero_q;

  // Status events: any hardware set pulse on request-zero bits six to one, software flag set
  assign evt_now[`PIEB_EVT_FLAG_SET] = |hs_set;
  assign evt_now[`PIEB_EVT_SOFT_SET] = wr_req && i_wdata[`PIEB_BIT_SOFT_IRQ];
  assign rd_stat = i_rd && (i_addr == `PIEB_OFF_EVT_STAT);

  always @* begin
    evt_stat_d = evt_stat_q;
    if (rd_stat) begin
      evt_stat_d = {`PIEB_EVT_W{1'b0}};
    end
    // Events in the read cycle survive the clear
    evt_stat_d = evt_stat_d | evt_now;
  end

  always @(posedge i_ref_clk) begin
    if (i_rst) begin
      evt_stat_q <= {`PIEB_EVT_W{1'b0}};
      evt_mask_q <= {`PIEB_EVT_W{1'b0}};
    end else begin
      evt_stat_q <= evt_stat_d;
      if (i_wr && (i_addr == `PIEB_OFF_EVT_MASK)) begin
        evt_mask_q <= i_wdata[`PIEB_EVT_W-1:0];
      end
    end
  end

  // Soft flag raises the line directly so software can force an interrupt
  assign o_irq = (|(evt_stat_q & evt_mask_q)) | (|o_req_zero) | soft_flag_q;

  always @* begin
    rdata_d = 8'h00;
    if (i_addr == `PIEB_OFF_EN_FIVE) begin
      rdata_d = en_five_q;
    end else if (i_addr == `PIEB_OFF_EN_SIX) begin
      rdata_d = en_six_q;
    end else if (i_addr == `PIEB_OFF_EN_SEVEN) begin
      rdata_d = en_seven_q;
    end else if (i_addr == `PIEB_OFF_EN_EIGHT) begin
      rdata_d = en_eight_q;
    end else if (i_addr == `PIEB_OFF_EN_NINE) begin
      rdata_d = en_nine_q;
    end else if (i_addr == `PIEB_OFF_EN_TEN) begin
      rdata_d = en_ten_q;
    end else if (i_addr == `PIEB_OFF_REQ_ZERO) begin
      rdata_d = flags_zero;
    end else if (i_addr == `PIEB_OFF_EVT_STAT) begin
      rdata_d = {6'h00, evt_stat_q};
    end else if (i_addr == `PIEB_OFF_EVT_MASK) begin
      rdata_d = {6'h00, evt_mask_q};
    end else if (i_addr == `PIEB_OFF_EVT_MASK + 12'h001) begin
      rdata_d = en_zero_q;
    end
  end

  always @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_rdata <= 8'h00;
    end else if (i_rd) begin
      o_rdata <= rdata_d;
    end else begin
      o_rdata <= 8'h00;
    end
  end
endmodule // pieb_enable_bank

// ==== pieb_enable_bank_assertions.sv ====
// Port assertions for the peripheral enable bank
`timescale 1ns/100ps
module pieb_enable_bank_assertions (
  input wire i_ref_clk,
  input wire i_rst,
  input wire i_wr,
  input wire i_rd,
  input wire [7:0] o_rdata,
  input wire [7:0] i_src_six,
  input wire [7:0] i_req_zero_set,
  input wire i_pin_change_any,
  input wire [7:0] o_req_six,
  input wire [7:0] o_req_zero,
  input wire [7:0] o_req_zero_flags,
  input wire o_irq
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  sequence hw_set_s; |i_req_zero_set[6:1]; endsequence
  idle_rdata_a: assert property (!i_rd |=> o_rdata == 8'h00) else $error("rdata");
  six_gate_a: assert property ((o_req_six & ~i_src_six) == 8'h00 && !o_req_six[1])
    else $error("gate");
  flag_set_a: assert property (hw_set_s |=>
    (o_req_zero_flags[6:1] & $past(i_req_zero_set[6:1])) == $past(i_req_zero_set[6:1]))
    else $error("set");
  flag_hold_a: assert property (!i_wr |=>
    (o_req_zero_flags[6:1] & $past(o_req_zero_flags[6:1])) == $past(o_req_zero_flags[6:1]))
    else $error("hold");
  pin_follow_a: assert property (1 |=> o_req_zero_flags[7] == $past(i_pin_change_any))
    else $error("pin");
  soft_only_a: assert property (!i_wr |=> $stable(o_req_zero_flags[0])) else $error("soft");
  soft_irq_a: assert property (o_req_zero_flags[0] |-> o_irq) else $error("irq");
  zero_fwd_a: assert property ((o_req_zero & ~o_req_zero_flags) == 8'h00) else $error("fwd");
endmodule // pieb_enable_bank_assertions
bind pieb_enable_bank pieb_enable_bank_assertions pieb_enable_bank_assertions_i (.i_ref_clk,
  .i_rst, .i_wr, .i_rd, .o_rdata, .i_src_six, .i_req_zero_set, .i_pin_change_any, .o_req_six,
  .o_req_zero, .o_req_zero_flags, .o_irq);

// ==== pieb_src_model.sv ====
// Source model: peripheral flag levels, set pulses, pin change
`timescale 1ns/100ps
module pieb_src_model (
  input wire i_ref_clk,
  input wire [56:0] i_ev,
  output reg [56:0] o_ev
);
  // Registered so sources move a clock after the bench asks, as real logic would
  always @(posedge i_ref_clk) begin
    o_ev <= i_ev;
  end
endmodule // pieb_src_model

// ==== pieb_enable_bank_tb.sv ====
// Self-checking bench for the peripheral enable bank
`timescale 1ns/100ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin miscompares++; \
  $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module pieb_enable_bank_tb;
  logic i_ref_clk = 0, i_rst = 1, i_wr = 0, i_rd = 0;
  logic [11:0] i_addr = 0;
  logic [7:0] i_wdata = 0, o_rdata, o_req_zero, zf, d;
  logic [56:0] ev = 0, s;
  logic [47:0] en;
  wire [47:0] req;
  wire o_irq;
  int miscompares = 0, num_checks = 0, cyc = 0;
  localparam logic [47:0] MSK = 48'hf9ffafeffd03;
  always #4 i_ref_clk = ~i_ref_clk;
  always @(posedge i_ref_clk) begin
    if (++cyc > 3000) begin
      miscompares++;
      complete_run();
    end
  end
  pieb_src_model pieb_src_model_i (.i_ref_clk, .i_ev(ev), .o_ev(s));
  pieb_enable_bank pieb_enable_bank_i (.i_ref_clk, .i_rst, .i_addr, .i_wdata, .i_wr, .i_rd,
    .o_rdata, .i_src_five(s[7:0]), .i_src_six(s[15:8]), .i_src_seven(s[23:16]),
    .i_src_eight(s[31:24]), .i_src_nine(s[39:32]), .i_src_ten(s[47:40]),
    .i_req_zero_set(s[55:48]), .i_pin_change_any(s[56]), .o_req_five(req[7:0]),
    .o_req_six(req[15:8]), .o_req_seven(req[23:16]), .o_req_eight(req[31:24]),
    .o_req_nine(req[39:32]), .o_req_ten(req[47:40]), .o_req_zero, .o_req_zero_flags(zf),
    .o_irq);
  // Requests are launched on a rising edge; results are sampled just after the edge
  task automatic wr(input [11:0] a, input [7:0] v);
    @(posedge i_ref_clk);
    i_addr <= a;
    i_wdata <= v;
    i_wr <= 1;
    @(posedge i_ref_clk) i_wr <= 0;
    #1;
  endtask
  task automatic rd(input [11:0] a);
    @(posedge i_ref_clk);
    i_addr <= a;
    i_rd <= 1;
    @(posedge i_ref_clk) i_rd <= 0;
    #1 d = o_rdata;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge i_ref_clk);
    #1;
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    void'($urandom(32'h3845));
    repeat (6) @(posedge i_ref_clk);
    i_rst <= 0;
    for (int k = 0; k < 7; k++) begin rd(12'(12'h4ad + k)); `CHK(d, 8'h00) end
    // All-ones pass first exposes any unimplemented bit that sticks
    for (int p = 0; p < 2; p++) begin
      en = p ? 48'({$urandom, $urandom}) : '1;
      for (int k = 0; k < 6; k++) begin
        wr(12'(12'h4ad + k), en[8*k+:8]);
        rd(12'(12'h4ad + k));
        `CHK(d, en[8*k+:8] & MSK[8*k+:8])
      end
    end
    en = en & MSK;
    repeat (16) begin
      @(posedge i_ref_clk) ev <= 57'({$urandom, $urandom}) & 57'h0ffffffffffff;
      tick(2);
      for (int k = 0; k < 6; k++) `CHK(req[8*k+:8], ev[8*k+:8] & en[8*k+:8])
    end
    wr(12'h4c2, 8'hff);
    wr(12'h4c1, 8'h00);
    d = 8'($urandom) & 8'h7e | 8'h02;
    // Set pulses on bits 7 and 0 must not reach the flags
    @(posedge i_ref_clk) ev[55:48] <= d | 8'h81;
    @(posedge i_ref_clk) ev[55:48] <= 8'h00;
    tick(2);
    `CHK(zf, d)
    `CHK(o_req_zero, d)
    `CHK(o_irq, 1'b1)
    wr(12'h4b3, 8'h80);
    rd(12'h4b3);
    `CHK(d, 8'h00)
    `CHK(o_irq, 1'b0)
    wr(12'h4b3, 8'h01);
    `CHK(zf, 8'h01)
    `CHK(o_irq, 1'b1)
    wr(12'h4b3, 8'h00);
    @(posedge i_ref_clk) ev[56] <= 1;
    tick(3);
    wr(12'h4b3, 8'h00);
    `CHK(zf[7], 1'b1)
    @(posedge i_ref_clk) ev[56] <= 0;
    tick(3);
    `CHK(zf[7], 1'b0)
    rd(12'h4c0);
    `CHK(d, 8'h03)
    wr(12'h4c2, 8'h00);
    wr(12'h4c1, 8'h01);
    @(posedge i_ref_clk) ev[55:48] <= 8'h40;
    @(posedge i_ref_clk) ev[55:48] <= 8'h00;
    tick(2);
    `CHK(o_irq, 1'b1)
    `CHK(zf, 8'h40)
    `CHK(o_req_zero, 8'h00)
    rd(12'h4c0);
    `CHK(d, 8'h01)
    `CHK(o_irq, 1'b0)
    wr(12'h123, 8'hff);
    rd(12'h123);
    `CHK(d, 8'h00)
    complete_run();
  end
endmodule // pieb_enable_bank_tb
